// >>> logic/fcu_buf_if.sv
// Segment buffer port group between the host core and its storage.
// Assumes one writer and two readers, all on pclk.
`timescale 1ns/100ps
interface fcu_buf_if #(parameter int DW = 32);
  logic          wen;
  logic [3:0]    widx;
  logic [DW-1:0] wdata;
  logic [3:0]    ridx_a;
  logic [3:0]    ridx_b;
  logic [DW-1:0] rdata_a;
  logic [DW-1:0] rdata_b;

  modport host (output wen, output widx, output wdata, output ridx_a, output ridx_b,
                input rdata_a, input rdata_b);
  modport mem  (input wen, input widx, input wdata, input ridx_a, input ridx_b,
                output rdata_a, output rdata_b);
endinterface

// >>> logic/fcu_host.sv
// User-side driver of a fast-cycle DRAM controller, commanded over APB.
// Assumes the controller shares pclk, so its user port needs no synchroniser.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/100ps
module fcu_host #(
  parameter int DW       = 32,
  parameter int COL_BITS = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output logic      [2:0]    usr_cmd,
  output logic      [26:0]   usr_addr,
  output logic      [3:0]    usr_num_xfers,
  output logic      [DW-1:0] usr_wdata,
  output logic      [1:0]    usr_read_dly,
  output logic               usr_ref_en,
  output logic      [15:0]   ref_interval,
  output logic      [3:0]    ref_burst,
  input  wire logic          usr_ack,
  input  wire logic          usr_dreq,
  input  wire logic          usr_dval,
  input  wire logic [DW-1:0] usr_rdata
);

  localparam logic [9:0] COL_KEEP = 10'((32'd1 << COL_BITS) - 32'd1);

  function automatic logic is_xfer(input logic [2:0] code);
    return (code == fcu_pkg::UCMD_READ) || (code == fcu_pkg::UCMD_WRITE);
  endfunction

  function automatic logic [3:0] clamp_burst(input logic [3:0] b);
    if (b < fcu_pkg::BURST_MIN) return fcu_pkg::BURST_MIN;
    if (b > fcu_pkg::BURST_MAX) return fcu_pkg::BURST_MAX;
    return b;
  endfunction

  fcu_pkg::fcu_state_t state_reg, state_next;
  logic [2:0]    cmd_reg, cmd_next;
  logic [2:0]    op_reg;
  logic [26:0]   addr_reg;
  logic [3:0]    num_reg;
  logic [3:0]    cnt_reg, cnt_next;
  logic [3:0]    wptr_reg, rptr_reg;
  logic [DW-1:0] wdata_reg;
  logic [1:0]    dly_reg;
  logic          refen_reg, done_reg, hold_reg;
  logic [15:0]   intv_reg;
  logic [3:0]    burst_reg;
  logic [31:0]   prdata_reg;
  logic          pready_reg, pslverr_reg;

  fcu_buf_if #(.DW(DW)) bif ();

  fcu_seg_mem #(.DW(DW)) u_mem (
    .pclk (pclk),
    .bus  (bif.mem)
  );

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // One wait state: data is registered on the same edge that raises pready
  wire        acc      = psel && penable;
  wire        fin      = acc && pready_reg;
  wire        wr_fin   = fin && pwrite;
  wire        rd_fin   = fin && !pwrite;
  wire        idle     = (state_reg == fcu_pkg::ST_IDLE);
  wire        hit_cmd  = (paddr == fcu_pkg::OFF_CMD);
  wire        hit_addr = (paddr == fcu_pkg::OFF_ADDR);
  wire        hit_cfg  = (paddr == fcu_pkg::OFF_CFG);
  wire        hit_ref  = (paddr == fcu_pkg::OFF_REF);
  wire        hit_st   = (paddr == fcu_pkg::OFF_STATUS);
  wire        hit_wd   = (paddr == fcu_pkg::OFF_WDATA);
  wire        hit_rd   = (paddr == fcu_pkg::OFF_RDATA);
  wire        hit_sr   = (paddr == fcu_pkg::OFF_SREF);
  wire        mapped   = hit_cmd | hit_addr | hit_cfg | hit_ref | hit_st | hit_wd
                       | hit_rd | hit_sr;
  wire [2:0]  req_code = pwdata[fcu_pkg::CMD_CODE_LSB +: 3];
  wire [3:0]  req_num  = pwdata[fcu_pkg::CMD_NUM_LSB +: 4];
  wire        num_ok   = (req_num != 4'h0) && (req_num <= fcu_pkg::NUM_MAX);
  wire        code_ok  = is_xfer(req_code) ? num_ok : (req_code[2] == 1'b1);
  wire        start    = wr_fin && hit_cmd && idle && code_ok;
  wire [26:0] addr_in  = {pwdata[26:10], pwdata[9:0] & COL_KEEP};
  wire        done_clr = wr_fin && hit_st && pwdata[fcu_pkg::ST_DONE_BIT];

  wire [31:0] status_word = {20'h0, cnt_reg, 5'h0, (state_reg == fcu_pkg::ST_SREF),
                             done_reg, !idle};
  wire [31:0] rd_mux =
      hit_cmd  ? {24'h0, num_reg, 1'b0, cmd_reg} :
      hit_addr ? {5'h0, addr_reg} :
      hit_cfg  ? {29'h0, dly_reg, refen_reg} :
      hit_ref  ? {12'h0, burst_reg, intv_reg} :
      hit_st   ? status_word :
      hit_rd   ? 32'(bif.rdata_b) :
      hit_sr   ? {31'h0, hold_reg} :
                 fcu_pkg::UNMAPPED_DATA;

  // ----------------------------------------
  // Segment counting and buffer access
  // ----------------------------------------
  wire seg_evt  = (op_reg == fcu_pkg::UCMD_WRITE) ? usr_dreq : usr_dval;
  wire xfer_act = (state_reg == fcu_pkg::ST_CMD) || (state_reg == fcu_pkg::ST_DATA);
  wire cap_en   = xfer_act && (op_reg == fcu_pkg::UCMD_READ) && usr_dval;
  wire last_seg = (cnt_next == num_reg);

  assign cnt_next = start ? 4'h0 : (xfer_act && seg_evt) ? 4'(cnt_reg + 4'h1) : cnt_reg;

  assign bif.wen    = cap_en || (wr_fin && hit_wd && idle);
  assign bif.widx   = cap_en ? cnt_reg : wptr_reg;
  assign bif.wdata  = cap_en ? usr_rdata : pwdata[DW-1:0];
  assign bif.ridx_a = cnt_next;
  assign bif.ridx_b = rptr_reg;

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    cmd_next   = cmd_reg;
    unique case (state_reg)
      fcu_pkg::ST_IDLE: begin
        if (start) begin
          state_next = (req_code == fcu_pkg::UCMD_SREF) ? fcu_pkg::ST_SREF : fcu_pkg::ST_CMD;
          cmd_next   = req_code;
        end
      end
      fcu_pkg::ST_CMD: begin
        // Inputs held until acknowledge; controller inserts its own idles
        if (usr_ack) begin
          cmd_next   = fcu_pkg::UCMD_NOP;
          state_next = (is_xfer(op_reg) && !last_seg) ? fcu_pkg::ST_DATA : fcu_pkg::ST_IDLE;
        end
      end
      fcu_pkg::ST_DATA: begin
        if (last_seg) begin
          state_next = fcu_pkg::ST_IDLE;
        end
      end
      fcu_pkg::ST_SREF: begin
        if (!hold_reg) begin
          cmd_next   = fcu_pkg::UCMD_AREF;
          state_next = fcu_pkg::ST_EXIT;
        end
      end
      fcu_pkg::ST_EXIT: begin
        if (usr_ack) begin
          cmd_next   = fcu_pkg::UCMD_NOP;
          state_next = fcu_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = fcu_pkg::ST_IDLE;
        cmd_next   = fcu_pkg::UCMD_NOP;
      end
    endcase
  end

  wire fin_evt = !idle && (state_next == fcu_pkg::ST_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= fcu_pkg::ST_IDLE;
      cmd_reg   <= fcu_pkg::UCMD_NOP;
      cnt_reg   <= 4'h0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_reg   <= cmd_next;
      cnt_reg   <= cnt_next;
      done_reg  <= fin_evt || (done_reg && !done_clr);
    end
  end

  // Command operands latch only at start, so they stay still until ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_reg    <= fcu_pkg::UCMD_NOP;
      num_reg   <= 4'h0;
      wdata_reg <= '0;
    end else begin
      if (start) begin
        op_reg  <= req_code;
        num_reg <= is_xfer(req_code) ? req_num : 4'h0;
      end
      if (start || (xfer_act && usr_dreq)) begin
        wdata_reg <= bif.rdata_a;
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg  <= 27'h0;
      dly_reg   <= 2'h0;
      refen_reg <= 1'b0;
      intv_reg  <= fcu_pkg::RST_INTERVAL;
      burst_reg <= fcu_pkg::RST_BURST;
      hold_reg  <= 1'b0;
      wptr_reg  <= 4'h0;
      rptr_reg  <= 4'h0;
    end else begin
      if (wr_fin && hit_addr && idle) addr_reg <= addr_in;
      if (wr_fin && hit_cfg) begin
        refen_reg <= pwdata[fcu_pkg::CFG_REFEN_BIT];
        dly_reg   <= pwdata[fcu_pkg::CFG_DLY_LSB +: 2];
      end
      if (wr_fin && hit_ref) begin
        intv_reg  <= pwdata[fcu_pkg::REF_INT_LSB +: 16] & fcu_pkg::INTERVAL_MASK;
        burst_reg <= clamp_burst(pwdata[fcu_pkg::REF_BURST_LSB +: 4]);
      end
      if (start && (req_code == fcu_pkg::UCMD_SREF)) begin
        hold_reg <= 1'b1;
      end else if (wr_fin && hit_sr) begin
        hold_reg <= pwdata[0];
      end
      if (start) begin
        wptr_reg <= 4'h0;
        rptr_reg <= 4'h0;
      end else begin
        if (wr_fin && hit_wd && idle) wptr_reg <= 4'(wptr_reg + 4'h1);
        if (rd_fin && hit_rd) rptr_reg <= 4'(rptr_reg + 4'h1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= acc && !pready_reg;
      pslverr_reg <= acc && !pready_reg && !mapped;
      if (acc && !pready_reg) prdata_reg <= rd_mux;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Bursting, masking and address stepping live in the controller
  assign usr_cmd       = cmd_reg;
  assign usr_addr      = addr_reg;
  assign usr_num_xfers = num_reg;
  assign usr_wdata     = wdata_reg;
  assign usr_read_dly  = dly_reg;
  assign usr_ref_en    = refen_reg;
  assign ref_interval  = intv_reg;
  assign ref_burst     = burst_reg;
  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cmd_held_stable: assert property ((state_reg == fcu_pkg::ST_CMD) && !usr_ack |=>
      $stable(usr_cmd) && $stable(usr_addr) && $stable(usr_num_xfers))
    else $error("command changed before acknowledge");
  a_ack_releases_cmd: assert property ((state_reg == fcu_pkg::ST_CMD) && usr_ack |=>
      usr_cmd == fcu_pkg::UCMD_NOP)
    else $error("command still driven after acknowledge");
  a_read_code_sent: assert property ((state_reg == fcu_pkg::ST_CMD) &&
      (op_reg == fcu_pkg::UCMD_READ) |-> usr_cmd == 3'h6)
    else $error("read request not coded 110");
  a_write_code_sent: assert property ((state_reg == fcu_pkg::ST_CMD) &&
      (op_reg == fcu_pkg::UCMD_WRITE) |-> usr_cmd == 3'h4)
    else $error("write request not coded 100");
  a_sref_held: assert property ((state_reg == fcu_pkg::ST_SREF) |->
      usr_cmd == 3'h5)
    else $error("self-refresh not held");
  a_sref_exit_aref: assert property ((state_reg == fcu_pkg::ST_SREF) && !hold_reg
      |=> (usr_cmd == 3'h7) ##0 (state_reg == fcu_pkg::ST_EXIT))
    else $error("no auto-refresh after self-refresh exit");
  a_wseg_advance: assert property (xfer_act && usr_dreq && (op_reg == fcu_pkg::UCMD_WRITE)
      && !start |=> cnt_reg == 4'($past(cnt_reg) + 4'h1))
    else $error("write segment not advanced after request");
  a_col_upper_zero: assert property ((usr_addr[9:0] & ~COL_KEEP) == 10'h0)
    else $error("unused column bits not zero");
  a_count_in_range: assert property ((state_reg == fcu_pkg::ST_CMD) && is_xfer(op_reg)
      |-> (usr_num_xfers >= 4'h1) && (usr_num_xfers <= 4'hf))
    else $error("transfer count out of range");
  a_burst_in_range: assert property ((ref_burst >= 4'h1) && (ref_burst <= 4'h8)
      && !ref_interval[15])
    else $error("refresh settings out of range");
  a_read_done_count: assert property ((state_reg == fcu_pkg::ST_DATA) &&
      (op_reg == fcu_pkg::UCMD_READ) && (state_next == fcu_pkg::ST_IDLE)
      |-> cnt_next == usr_num_xfers)
    else $error("read finished with wrong segment count");

  c_write_done: cover property ((op_reg == fcu_pkg::UCMD_WRITE) && fin_evt);
  c_read_done: cover property ((op_reg == fcu_pkg::UCMD_READ) && fin_evt && (num_reg > 4'h2));
  c_sref_cycle: cover property ((state_reg == fcu_pkg::ST_EXIT) && usr_ack);
  c_apb_error: cover property (pslverr && pready);

endmodule

// >>> logic/fcu_pkg.sv
// Shared constants of the user-port host: register map, fields, command codes.
// Assumes a 32-bit APB register bus and a user port in the same clock domain.
package fcu_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_CFG    = 8'h08;
  localparam logic [7:0] OFF_REF    = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_WDATA  = 8'h14;
  localparam logic [7:0] OFF_RDATA  = 8'h18;
  localparam logic [7:0] OFF_SREF   = 8'h1c;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CMD_CODE_LSB  = 0;
  localparam int CMD_NUM_LSB   = 4;
  localparam int CFG_REFEN_BIT = 0;
  localparam int CFG_DLY_LSB   = 1;
  localparam int REF_INT_LSB   = 0;
  localparam int REF_BURST_LSB = 16;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_DONE_BIT   = 1;
  localparam int ST_SREF_BIT   = 2;
  localparam int ST_CNT_LSB    = 8;

  // ----------------------------------------
  // User command codes
  // ----------------------------------------
  localparam logic [2:0] UCMD_NOP   = 3'h0;
  localparam logic [2:0] UCMD_WRITE = 3'h4;
  localparam logic [2:0] UCMD_SREF  = 3'h5;
  localparam logic [2:0] UCMD_READ  = 3'h6;
  localparam logic [2:0] UCMD_AREF  = 3'h7;

  // ----------------------------------------
  // Limits and reset values
  // ----------------------------------------
  localparam logic [3:0]  NUM_MAX       = 4'hf;
  localparam logic [3:0]  BURST_MIN     = 4'h1;
  localparam logic [3:0]  BURST_MAX     = 4'h8;
  localparam logic [15:0] INTERVAL_MASK = 16'h7fff;
  localparam logic [15:0] RST_INTERVAL  = 16'h0400;
  localparam logic [3:0]  RST_BURST     = 4'h1;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CMD  = 5'b00010,
    ST_DATA = 5'b00100,
    ST_SREF = 5'b01000,
    ST_EXIT = 5'b10000
  } fcu_state_t;

endpackage

// >>> logic/fcu_seg_mem.sv
// Sixteen-word segment store: write data staged by software, read data captured.
// Assumes writes come from one source per cycle; reads are combinational.
`timescale 1ns/100ps
module fcu_seg_mem #(
  parameter int DW = 32
) (
  input  wire logic pclk,
  fcu_buf_if.mem    bus
);

  logic [DW-1:0] mem_q [16];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // No reset: contents are data, never control
  always_ff @(posedge pclk) begin
    if (bus.wen) begin
      mem_q[bus.widx] <= bus.wdata;
    end
  end

  assign bus.rdata_a = mem_q[bus.ridx_a];
  assign bus.rdata_b = mem_q[bus.ridx_b];

endmodule

// >>> verif/fcu_ctrl_model.sv
// Behavioural controller on the far side of the host's user port.
// Assumes pclk is shared; lat adds idle cycles before each acknowledge.
`timescale 1ns/100ps
module fcu_ctrl_model #(
  parameter int DW = 32
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [2:0]    usr_cmd,
  input  wire logic [3:0]    usr_num_xfers,
  input  wire logic [DW-1:0] usr_wdata,
  input  wire logic [1:0]    usr_read_dly,
  input  wire logic [1:0]    lat,
  output logic               usr_ack,
  output logic               usr_dreq,
  output logic               usr_dval,
  output logic      [DW-1:0] usr_rdata
);
  // --------------------------------
  // Sequencer
  // --------------------------------
  logic [DW-1:0] mem_reg [16];
  logic [2:0]    st_reg;
  logic [2:0]    op_reg;
  logic [3:0]    cnt_reg;
  logic [3:0]    num_reg;
  logic [3:0]    seg_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= 3'h0;
      op_reg <= 3'h0;
      cnt_reg <= 4'h0;
      num_reg <= 4'h0;
      seg_reg <= 4'h0;
      usr_ack <= 1'b0;
      usr_dreq <= 1'b0;
      usr_dval <= 1'b0;
      usr_rdata <= '0;
    end else begin
      usr_ack <= 1'b0;
      // Released data lines keep the last segment one cycle, then invert every cycle
      if (!usr_dval) usr_rdata <= ~usr_rdata;
      case (st_reg)
        // Self refresh: stays idle while code 101 is held
        3'h0: if (usr_cmd inside {3'h4, 3'h6, 3'h7}) begin
          st_reg <= 3'h1;
          op_reg <= usr_cmd;
          num_reg <= usr_num_xfers;
          cnt_reg <= {2'h0, lat};
        end
        3'h1: if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
        else begin
          usr_ack <= 1'b1;
          seg_reg <= 4'h0;
          st_reg <= 3'h5;
          if (op_reg == 3'h4) begin
            st_reg <= 3'h2;
            usr_dreq <= 1'b1;
            cnt_reg <= num_reg - 4'h1;
          end else if (op_reg == 3'h6) begin
            st_reg <= 3'h3;
            cnt_reg <= {2'h0, usr_read_dly} + 4'h2;
          end
        end
        3'h2: begin
          mem_reg[seg_reg] <= usr_wdata;
          seg_reg <= seg_reg + 4'h1;
          if (cnt_reg == 4'h0) begin
            usr_dreq <= 1'b0;
            st_reg <= 3'h5;
          end else cnt_reg <= cnt_reg - 4'h1;
        end
        3'h3: if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
        else begin
          st_reg <= 3'h4;
          usr_dval <= 1'b1;
          usr_rdata <= mem_reg[0];
          seg_reg <= 4'h1;
          cnt_reg <= num_reg - 4'h1;
        end
        // Any count from 1 to 15: exactly num_reg segments shown, one per cycle (count 0 shows 16)
        3'h4: if (cnt_reg == 4'h0) begin
          usr_dval <= 1'b0;
          st_reg <= 3'h5;
        end else begin
          cnt_reg <= cnt_reg - 4'h1;
          usr_rdata <= mem_reg[seg_reg];
          seg_reg <= seg_reg + 4'h1;
        end
        // One quiet cycle so the acknowledged command is not taken twice
        default: st_reg <= 3'h0;
      endcase
    end
  end
endmodule

// >>> verif/tb_fast_cycle_dram_user_port.sv
// Self-checking bench: APB master, controller model, queued expectations.
// Assumes the host answers APB with one wait state and shares pclk.
`timescale 1ns/100ps
module tb_fast_cycle_dram_user_port;
  typedef struct {logic [32:0] v; logic [32:0] m;} fcu_exp_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic usr_ack, usr_dreq, usr_dval, usr_ref_en, ack_d;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, usr_wdata, usr_rdata;
  logic [2:0] usr_cmd;
  // Starts at NOP so the first edges do not compare against an unknown
  logic [2:0] cmd_d = 3'h0;
  logic [26:0] usr_addr;
  logic [3:0] usr_num_xfers, ref_burst;
  logic [1:0] usr_read_dly, lat;
  logic [15:0] ref_interval, lfsr;
  logic [31:0] segs [16];
  fcu_exp_t rq[$];
  logic [31:0] wq[$];
  int error_cnt, tests_run;

  fcu_host #(.DW(32), .COL_BITS(8)) u_fcu_host (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .usr_cmd(usr_cmd),
    .usr_addr(usr_addr), .usr_num_xfers(usr_num_xfers), .usr_wdata(usr_wdata),
    .usr_read_dly(usr_read_dly), .usr_ref_en(usr_ref_en), .ref_interval(ref_interval),
    .ref_burst(ref_burst), .usr_ack(usr_ack), .usr_dreq(usr_dreq), .usr_dval(usr_dval),
    .usr_rdata(usr_rdata));
  fcu_ctrl_model #(.DW(32)) u_fcu_ctrl_model (.pclk(pclk), .presetn(presetn),
    .usr_cmd(usr_cmd), .usr_num_xfers(usr_num_xfers), .usr_wdata(usr_wdata),
    .usr_read_dly(usr_read_dly), .lat(lat), .usr_ack(usr_ack), .usr_dreq(usr_dreq),
    .usr_dval(usr_dval), .usr_rdata(usr_rdata));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // --------------------------------
  // Checking
  // --------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_apb(input fcu_exp_t e, input logic [32:0] g);
    if (e.m != 33'h0) tests_run++;
    if ((g & e.m) !== (e.v & e.m)) begin
      error_cnt++;
      $display("ERROR apb read expected %h seen %h", e.v, g);
    end
  endtask

  // Watcher: bus reads, write segments, command sequencing
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (rq.size() == 0) chk("read queue", 32'h1, 32'h0);
      else chk_apb(rq.pop_front(), {pslverr, prdata});
    end
    if (usr_dreq === 1'b1) begin
      if (wq.size() == 0) chk("write queue", 32'h1, 32'h0);
      else chk("usr_wdata", wq.pop_front(), usr_wdata);
    end
    if (cmd_d === 3'h5 && usr_cmd !== 3'h5) chk("exit cmd", 32'h7, 32'(usr_cmd));
    if (ack_d === 1'b1) chk("cmd after ack", 32'h0, 32'(usr_cmd));
    else if (cmd_d !== 3'h0 && cmd_d !== 3'h5) chk("cmd held", 32'(cmd_d), 32'(usr_cmd));
    cmd_d <= usr_cmd;
    ack_d <= usr_ack;
  end

  // --------------------------------
  // Bus tasks
  // --------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input fcu_exp_t e, output logic [31:0] rd);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    if (i == 20) begin
      error_cnt++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, '{33'h0, 33'h0}, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [32:0] v, input logic [32:0] m,
                     output logic [31:0] x);
    apb(1'b0, a, 32'h0, '{v, m}, x);
  endtask

  task automatic wait_cmd(input logic [2:0] c);
    int k;
    for (k = 0; k < 10; k++) begin
      @(negedge pclk);
      if (usr_cmd === c) break;
    end
    chk("usr_cmd", 32'(c), 32'(usr_cmd));
  endtask

  task automatic wait_done();
    logic [31:0] x;
    int k;
    for (k = 0; k < 80; k++) begin
      rdc(fcu_pkg::OFF_STATUS, 33'h0, 33'h0, x);
      if (x[fcu_pkg::ST_DONE_BIT] === 1'b1) break;
    end
    if (k == 80) begin
      error_cnt++;
      wrap_up();
    end
    rdc(fcu_pkg::OFF_STATUS, 33'h0, 33'h1, x);
    wr(fcu_pkg::OFF_STATUS, 32'h2);
  endtask

  task automatic run_cmd(input logic [2:0] c, input logic [3:0] n);
    logic [31:0] x, a;
    int k;
    lat <= lfsr[1:0];
    for (k = 0; k < n && c == fcu_pkg::UCMD_WRITE; k++) begin
      lfsr = lfsr_next(lfsr);
      segs[k] = {lfsr, ~lfsr};
      wq.push_back(segs[k]);
      wr(fcu_pkg::OFF_WDATA, segs[k]);
    end
    lfsr = lfsr_next(lfsr);
    a = {5'h0, lfsr, 11'h7ff};
    wr(fcu_pkg::OFF_ADDR, a);
    wr(fcu_pkg::OFF_CMD, {24'h0, n, 1'b0, c});
    wait_cmd(c);
    // Column bits 9..8 unused by the byte-wide part
    chk("usr_addr", {5'h0, a[26:10], 2'h0, a[7:0]}, 32'(usr_addr));
    if (c != fcu_pkg::UCMD_AREF) chk("usr_num_xfers", 32'(n), 32'(usr_num_xfers));
    @(posedge pclk);
    wait_done();
    for (k = 0; k < n && c == fcu_pkg::UCMD_READ; k++)
      rdc(fcu_pkg::OFF_RDATA, {1'b0, segs[k]}, {33{1'b1}}, x);
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    logic [31:0] x;
    static logic [31:0] ref_in [3] = '{32'h0009_ffff, 32'h0000_0000, 32'h0005_1234};
    static logic [19:0] ref_ex [3] = '{20'h8_7fff, 20'h1_0000, 20'h5_1234};
    static logic [2:0] cmd_tab [6] = '{3'h4, 3'h6, 3'h4, 3'h6, 3'h4, 3'h6};
    static logic [3:0] num_tab [6] = '{4'h1, 4'h1, 4'hf, 4'hf, 4'h5, 4'h5};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lat = 2'h0;
    lfsr = 16'h0002;
    error_cnt = 0;
    tests_run = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("usr_cmd", 32'h0, 32'(usr_cmd));
    chk("ref", 32'h1_0400, {12'h0, ref_burst, ref_interval});
    @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      wr(fcu_pkg::OFF_REF, ref_in[i]);
      chk("ref", 32'(ref_ex[i]), {12'h0, ref_burst, ref_interval});
    end
    for (int i = 0; i < 4; i++) begin
      wr(fcu_pkg::OFF_CFG, 32'(i * 3));
      // Only bits 2..0 exist; bit 3 of the last value is dropped
      chk("cfg", 32'(i * 3) & 32'h7, {29'h0, usr_read_dly, usr_ref_en});
    end
    rdc(8'h20, {1'b1, 32'h0}, {33{1'b1}}, x);
    for (int i = 0; i < 2; i++) begin
      // Write with count zero, then a code below 100
      wr(fcu_pkg::OFF_CMD, (i == 0) ? 32'h0000_0004 : 32'h0000_0023);
      chk("refused cmd", 32'h0, 32'(usr_cmd));
    end
    for (int i = 0; i < 6; i++) run_cmd(cmd_tab[i], num_tab[i]);
    run_cmd(fcu_pkg::UCMD_AREF, 4'h0);
    wr(fcu_pkg::OFF_CMD, 32'(fcu_pkg::UCMD_SREF));
    wait_cmd(fcu_pkg::UCMD_SREF);
    @(posedge pclk);
    rdc(fcu_pkg::OFF_STATUS, 33'h4, 33'h4, x);
    wr(fcu_pkg::OFF_SREF, 32'h0);
    wait_done();
    wrap_up();
  end
endmodule
